// ==== pph_pkg.sv ====
// Package for the parallel port host-mode block: register layout, pin modes, carrier struct.
package pph_pkg;
  localparam int          CTRL_W        = 16;          // Control register width
  localparam int          STAT_W        = 8;           // Host status register width
  localparam int          BUS_W         = 16;          // Parallel bus width
  localparam int          CTL_SERIN_B   = 15;          // Copy of serial input full status
  localparam int          CTL_STRB_HI   = 14;          // Strobe width field top
  localparam int          CTL_STRB_LO   = 13;          // Strobe width field bottom
  localparam int          CTL_ODIR_B    = 12;          // Output strobe active when set
  localparam int          CTL_IDIR_B    = 11;          // Input strobe active when set
  localparam int          CTL_RSV_B     = 10;          // Reserved bit
  localparam int          CTL_IEN_HI    = 9;           // Interrupt enables top
  localparam int          CTL_IEN_LO    = 5;           // Interrupt enables bottom
  localparam int          CTL_IEN_IN_B  = 7;           // Input strobe interrupt enable
  localparam int          CTL_IEN_OUT_B = 6;           // Output strobe interrupt enable
  localparam int          CTL_ST_SER_B  = 4;           // Serial input full status
  localparam int          CTL_ST_SOE_B  = 3;           // Serial output empty status
  localparam int          CTL_ST_IN_B   = 2;           // Output strobe event status; input strobe events set ctrl_ff bit 3
  localparam int          CTL_ST_OUT_B  = 1;           // Strobe event status slot, never set by either strobe
  localparam int          CTL_ST_EXT_B  = 0;           // External interrupt pin status
  localparam int          ST_ACTIN_B    = 2;           // Input active indicator in host status
  localparam int          ST_IFULL_B    = 1;           // Input full flag in host status
  localparam int          ST_OEMPTY_B   = 0;           // Output empty flag in host status
  localparam logic [15:0] CTRL_RST      = 16'h0008;    // Reset: all clear except bit 3
  localparam logic [15:0] CTRL_WMASK    = 16'h7BE0;    // Software writable bits
  localparam logic [2:0]  STRB_CNT_MAX  = 3'h4;        // Longest strobe width in periods

  // Pin mode of the two strobes
  typedef enum logic [1:0] {
    PPH_ACT_ACT = 2'b11,
    PPH_ACT_PAS = 2'b10,
    PPH_PAS_ACT = 2'b01,
    PPH_PAS_PAS = 2'b00
  } pph_mode_e;

  // Host-side pins as seen by the device
  typedef struct packed {
    logic              host_enable_n;       // Active-low chip select
    logic              status_data_select;  // High selects status
    logic              input_strobe_n;      // Host write strobe
    logic              output_strobe_n;     // Host read strobe
  } pph_host_s;
endpackage

// ==== pph_port.sv ====
// Passive and peripheral side of the parallel host port with control register.
`timescale 1ns/10ps
module pph_port
  import pph_pkg::*;
(
  input  wire logic              core_clk_i,      // Core clock, 20 MHz
  input  wire logic              rst_n_i,         // Synchronous active-low reset
  input  wire logic              output_clock_i,  // Output clock level, same domain
  input  wire pph_host_s         host_i,          // Asynchronous host pins
  input  wire logic [BUS_W-1:0]  bus_i,           // Parallel bus input
  output logic      [BUS_W-1:0]  bus_o,           // Parallel bus output
  output logic                   bus_oe_o,        // Parallel bus drive enable
  output logic      [2:0]        sel_o,           // Port select pin outputs
  output logic      [2:0]        sel_oe_o,        // Port select pin drive enables
  output logic                   input_full_flag_o,  // Input buffer full pin
  output logic                   output_empty_flag_o,// Output buffer empty pin
  output logic                   irq_in_o,        // Internal input strobe interrupt
  output logic                   irq_out_o,       // Internal output strobe interrupt
  input  wire logic              cpu_ctrl_we_i,   // Program writes control register
  input  wire logic [CTRL_W-1:0] cpu_ctrl_wdata_i,// Control write data
  output logic      [CTRL_W-1:0] cpu_ctrl_rdata_o,// Control read data
  input  wire logic              cpu_port_rd_i,   // Program reads a logical port
  input  wire logic              cpu_port_wr_i,   // Program writes a logical port
  input  wire logic [2:0]        cpu_port_num_i,  // Logical port number
  input  wire logic [BUS_W-1:0]  cpu_wdata_i,     // Data to output register
  output logic      [BUS_W-1:0]  cpu_rdata_o,     // Data from input register
  input  wire logic              serial_input_full_status_i, // Serial input full status
  input  wire logic              serial_out_empty_i,// Serial output empty status
  input  wire logic              ext_int_i        // External interrupt pin status
);

  // Synchroniser stages, first stage read only by second
  pph_host_s         sync1_ff;                  // First stage
  pph_host_s         sync2_ff;                  // Second stage
  pph_host_s         prev_ff;                   // Previous synced value for edges
  logic [BUS_W-1:0]  bus1_ff;                   // Bus sync first stage
  logic [BUS_W-1:0]  bus2_ff;                   // Bus sync second stage
  logic [CTRL_W-1:0] ctrl_ff;                   // Control register
  logic [BUS_W-1:0]  in_reg_ff;                 // Physical input register
  logic [BUS_W-1:0]  out_reg_ff;                // Physical output register
  logic              ifull_ff;                  // Input full flag
  logic              oempty_ff;                 // Output empty flag
  logic              ifull_pend_ff;             // Input full waiting on clock phase
  logic              oempty_pend_ff;            // Output empty waiting on clock phase
  logic              ifull_arm_ff;              // Input full request saw a high phase begin
  logic              oempty_arm_ff;             // Output empty request saw a high phase begin
  logic              ck_prev_ff;                // Output clock previous level
  logic [2:0]        sel_num_ff;                // Active port number latch
  logic [2:0]        sel_ff;                    // Select pin outputs
  logic [2:0]        sel_oe_ff;                 // Select pin enables
  logic [BUS_W-1:0]  bus_o_ff;                  // Bus output register
  logic              bus_oe_ff;                 // Bus enable register
  logic              irq_in_ff;                 // Input interrupt output
  logic              irq_out_ff;                // Output interrupt output
  logic [CTRL_W-1:0] ctrl_rd_ff;                // Control read register
  logic [BUS_W-1:0]  cpu_rd_ff;                 // Input register read register

  // Decoded modes
  wire logic      in_passive  = ~ctrl_ff[CTL_IDIR_B];
  wire logic      out_passive = ~ctrl_ff[CTL_ODIR_B];
  wire pph_mode_e mode        = pph_mode_e'({ctrl_ff[CTL_ODIR_B], ctrl_ff[CTL_IDIR_B]});
  wire logic      periph      = (mode == PPH_PAS_PAS);
  wire logic      enabled     = ~sync2_ff.host_enable_n;
  // Strobe edges gated by enable
  wire logic      in_rise   = in_passive & enabled & ~prev_ff.input_strobe_n & sync2_ff.input_strobe_n;
  wire logic      out_low   = out_passive & enabled & ~sync2_ff.output_strobe_n;
  wire logic      out_rise  = out_passive & enabled & ~prev_ff.output_strobe_n & sync2_ff.output_strobe_n;
  wire logic      rd_status = sync2_ff.status_data_select;
  // Output clock edges; each flag waits for a high phase begun after its own request
  wire logic      ck_rise  = ~ck_prev_ff & output_clock_i;
  wire logic      ck_fall  = ck_prev_ff & ~output_clock_i;
  wire logic      in_done  = ifull_arm_ff & ck_fall;
  wire logic      out_done = oempty_arm_ff & ck_fall;
  // Active strobe width in output clock periods, read only by the a_strobe_span check
  wire logic [2:0] strobe_periods = {1'b0, ctrl_ff[CTL_STRB_HI:CTL_STRB_LO]} + 3'h1;
  wire logic [STAT_W-1:0] status_byte = {5'h00, ~in_passive, ifull_ff, oempty_ff};
  wire logic [BUS_W-1:0]  bus_data = rd_status ? {{(BUS_W-STAT_W){1'b0}}, status_byte} : out_reg_ff;
  wire logic [CTRL_W-1:0] status_bits = {serial_input_full_status_i, ctrl_ff[14:5],
                                         serial_input_full_status_i, serial_out_empty_i,
                                         ctrl_ff[CTL_ST_IN_B], ctrl_ff[CTL_ST_OUT_B], ext_int_i};
  wire logic [CTRL_W-1:0] ctrl_wr = (cpu_ctrl_wdata_i & CTRL_WMASK) | (ctrl_ff & ~CTRL_WMASK);
  wire logic      set_in_st  = in_rise;
  wire logic      set_out_st = out_rise & ~rd_status;
  wire logic [CTRL_W-1:0] nxt_ctrl = (cpu_ctrl_we_i ? ctrl_wr : ctrl_ff)
                                   | ({{(CTRL_W-3){1'b0}}, set_in_st, set_out_st, 1'b0} << 1);

  // Select pin drive: port number, or ready, per mode
  wire logic [2:0] nxt_sel_oe = (mode == PPH_ACT_ACT) ? 3'h7 :
                                (mode == PPH_ACT_PAS) ? 3'h3 : 3'h1;
  wire logic [2:0] nxt_sel    = periph ? {2'b00, ifull_ff | oempty_ff} : sel_num_ff;

  // Synchronise host pins and bus
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      sync1_ff <= '1;
      sync2_ff <= '1;
      prev_ff  <= '1;
      bus1_ff  <= '0;
      bus2_ff  <= '0;
    end else begin
      sync1_ff <= host_i;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
      bus1_ff  <= bus_i;
      bus2_ff  <= bus1_ff;
    end
  end

  // Control register: status set wins over software write
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= CTRL_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Data registers shared by all logical ports
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      in_reg_ff  <= '0;
      out_reg_ff <= '0;
      sel_num_ff <= '0;
    end else begin
      if (in_rise) begin
        in_reg_ff <= bus2_ff;
      end
      if (cpu_port_wr_i) begin
        out_reg_ff <= cpu_wdata_i;
      end
      if (cpu_port_wr_i || cpu_port_rd_i) begin
        sel_num_ff <= cpu_port_num_i;
      end
    end
  end

  // Output clock phase tracker; a high phase already running at the request never counts
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ck_prev_ff    <= 1'b0;
      ifull_arm_ff  <= 1'b0;
      oempty_arm_ff <= 1'b0;
    end else begin
      ck_prev_ff    <= output_clock_i;
      ifull_arm_ff  <= ifull_pend_ff & ~in_rise & ~in_done & (ifull_arm_ff | ck_rise);
      oempty_arm_ff <= oempty_pend_ff & ~set_out_st & ~out_done & (oempty_arm_ff | ck_rise);
    end
  end

  // Buffer flags; pending sets wait for a full high phase
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      ifull_ff       <= 1'b0;
      oempty_ff      <= 1'b0;
      ifull_pend_ff  <= 1'b0;
      oempty_pend_ff <= 1'b0;
    end else begin
      ifull_pend_ff  <= in_passive & ((ifull_pend_ff & ~in_done) | in_rise);
      oempty_pend_ff <= out_passive & ((oempty_pend_ff & ~out_done) | set_out_st);
      // Set wins over clear from the program
      ifull_ff  <= in_passive & (in_done | (ifull_ff & ~cpu_port_rd_i));
      oempty_ff <= out_passive & (out_done | (oempty_ff & ~cpu_port_wr_i));
    end
  end

  // Pin and interrupt outputs
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      bus_o_ff   <= '0;
      bus_oe_ff  <= 1'b0;
      sel_ff     <= '0;
      sel_oe_ff  <= 3'h0;
      irq_in_ff  <= 1'b0;
      irq_out_ff <= 1'b0;
      ctrl_rd_ff <= CTRL_RST;
      cpu_rd_ff  <= '0;
    end else begin
      bus_oe_ff  <= out_low;
      bus_o_ff   <= bus_data;
      sel_ff     <= nxt_sel;
      sel_oe_ff  <= nxt_sel_oe;
      irq_in_ff  <= set_in_st & ctrl_ff[CTL_IEN_IN_B];
      irq_out_ff <= set_out_st & ctrl_ff[CTL_IEN_OUT_B];
      ctrl_rd_ff <= status_bits;
      cpu_rd_ff  <= in_reg_ff;
    end
  end

  assign bus_o               = bus_o_ff;
  assign bus_oe_o            = bus_oe_ff;
  assign sel_o               = sel_ff;
  assign sel_oe_o            = sel_oe_ff;
  assign input_full_flag_o   = ifull_ff;
  assign output_empty_flag_o = oempty_ff;
  assign irq_in_o            = irq_in_ff;
  assign irq_out_o           = irq_out_ff;
  assign cpu_ctrl_rdata_o    = ctrl_rd_ff;
  assign cpu_rdata_o         = cpu_rd_ff;

  // Checks
  sequence s_in_release;
    in_rise;
  endsequence

  a_flag_gate_in: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !in_passive |=> !ifull_ff) else $error("input full set while strobe active");
  a_flag_gate_out: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !out_passive |=> !oempty_ff) else $error("output empty set while strobe active");
  a_ready_or: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    periph |=> sel_ff[0] == $past(ifull_ff | oempty_ff)) else $error("ready pin not flag OR");
  a_bus_drive: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    out_low |=> bus_oe_ff) else $error("bus not driven on read");
  a_bus_release: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !out_low |=> !bus_oe_ff) else $error("bus driven after read");
  a_status_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (out_rise && rd_status) |=> !irq_out_ff) else $error("status read raised interrupt");
  a_irq_in_mask: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    s_in_release |=> irq_in_ff == $past(ctrl_ff[CTL_IEN_IN_B])) else $error("input interrupt wrong");
  // A disabled host must leave the input register, the bus and the interrupts alone
  a_ignore_dis: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    sync2_ff.host_enable_n |=> (in_reg_ff == $past(in_reg_ff)) && !bus_oe_ff && !irq_in_ff && !irq_out_ff)
    else $error("disabled strobe acted");
  // A flag needs a whole output clock high phase, so never sets within two cycles
  a_full_wait: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (in_rise && !ifull_ff && !ifull_pend_ff) |=> !ifull_ff [*2]) else $error("input full set too soon");
  a_empty_wait: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (set_out_st && !oempty_ff && !oempty_pend_ff) |=> !oempty_ff [*2]) else $error("output empty set too soon");
  a_strobe_span: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (ctrl_ff[CTL_STRB_HI:CTL_STRB_LO] == 2'b11) |-> strobe_periods == STRB_CNT_MAX)
    else $error("strobe width decode wrong");
endmodule // pph_port

// ==== pph_host_model.sv ====
// Host processor model that drives the passive strobes, the enable, the select and the bus.
`timescale 1ns/10ps
module pph_host_model
  import pph_pkg::*;
(
  input  wire logic        core_clk_i, // Pacing clock
  output pph_host_s        host_o,     // Host control pins
  output logic [BUS_W-1:0] bus_o       // Host drive onto the bus
);
  logic [BUS_W-1:0] drv_ff; // Last word driven
  logic             drv_on; // Host drives the bus

  // A released bus shows the inverse, so stale data never passes for valid data
  assign bus_o = drv_on ? drv_ff : ~drv_ff;

  // Idle pins: not enabled, strobes high
  initial begin
    host_o = '{1'b1, 1'b0, 1'b1, 1'b1};
    drv_ff = '0;
    drv_on = 1'b0;
  end

  // Passive write; en_n high breaks the enable order on purpose
  task automatic write_word(input logic [BUS_W-1:0] d, input logic en_n);
    host_o.host_enable_n <= en_n;
    @(posedge core_clk_i);
    host_o.input_strobe_n <= 1'b0;
    drv_ff <= d;
    drv_on <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    host_o.input_strobe_n <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    drv_on <= 1'b0;
    host_o.host_enable_n <= 1'b1;
    @(posedge core_clk_i);
  endtask

  // Passive read: select high for status, low for output data
  task automatic read_word(input logic sel);
    host_o.host_enable_n <= 1'b0;
    host_o.status_data_select <= sel;
    @(posedge core_clk_i);
    host_o.output_strobe_n <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    host_o.output_strobe_n <= 1'b1;
    repeat (5) @(posedge core_clk_i);
    host_o.host_enable_n <= 1'b1;
    @(posedge core_clk_i);
  endtask
endmodule // pph_host_model

// ==== testbench.sv ====
// Self-checking bench for the parallel host port.
`timescale 1ns/10ps
module testbench;
  import pph_pkg::*;
  typedef struct packed { logic [15:0] val; logic [15:0] mask; } pph_exp_s;
  logic core_clk_i, rst_n_i, output_clock_i, bus_oe_o, ifl, oef, irq_in, irq_out, we, prd, pwr;
  logic sifs, ext_int;  // Serial input full and external interrupt levels, driven at random
  logic [15:0] bus_o, wdata, crdata, cwdata, rdata, d, wd;
  logic [2:0]  sel_o, sel_oe, pnum;
  logic [1:0]  oc_cnt;
  wire  [15:0] hbus;
  wire  [15:0] bus_in = bus_oe_o ? bus_o : hbus; // Resolved bus level
  pph_host_s   host_w;
  pph_exp_s    expq[$];  // Expected words on the bus
  pph_exp_s    e;
  int failures, compares, n_in, n_out, cyc;
  logic oe_q;

  pph_host_model host (.core_clk_i(core_clk_i), .host_o(host_w), .bus_o(hbus));
  pph_port DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .output_clock_i(output_clock_i),
    .host_i(host_w), .bus_i(bus_in), .bus_o(bus_o), .bus_oe_o(bus_oe_o), .sel_o(sel_o),
    .sel_oe_o(sel_oe), .input_full_flag_o(ifl), .output_empty_flag_o(oef), .irq_in_o(irq_in),
    .irq_out_o(irq_out), .cpu_ctrl_we_i(we), .cpu_ctrl_wdata_i(wdata), .cpu_ctrl_rdata_o(crdata),
    .cpu_port_rd_i(prd), .cpu_port_wr_i(pwr), .cpu_port_num_i(pnum), .cpu_wdata_i(cwdata),
    .cpu_rdata_o(rdata), .serial_input_full_status_i(sifs), .serial_out_empty_i(1'b1),
    .ext_int_i(ext_int));

  // Core clock, 50 ns period
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  // Output clock at a quarter of the core rate; counts interrupt pulses; cuts a hang short
  always @(posedge core_clk_i) begin
    oc_cnt <= oc_cnt + 2'h1;
    output_clock_i <= oc_cnt[1];
    if (irq_in === 1'b1) n_in++;
    if (irq_out === 1'b1) n_out++;
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end

  // Bus monitor: first sampled drive edge takes the oldest note
  always @(posedge core_clk_i) begin
    oe_q <= bus_oe_o;
    if (bus_oe_o === 1'b1 && oe_q !== 1'b1) begin
      if (expq.size() == 0) e = '{16'h0000, 16'hFFFF};
      else e = expq.pop_front();
      cmp_word(bus_o, e.val, e.mask);
    end
  end

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] m);
    compares++;
    if ((got & m) !== (exp & m)) begin
      failures++;
      $display("BAD %0t word got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t bit got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic ctrl_wr(input logic [15:0] v);
    we <= 1'b1;
    wdata <= v;
    @(posedge core_clk_i);
    we <= 1'b0;
    repeat (2) @(posedge core_clk_i);
  endtask

  // Program port access; the port number is random where no test needs one
  task automatic port_op(input logic wr, input logic [15:0] v, input logic [2:0] n);
    pwr <= wr;
    prd <= ~wr;
    cwdata <= v;
    pnum <= n;
    @(posedge core_clk_i);
    pwr <= 1'b0;
    prd <= 1'b0;
    repeat (3) @(posedge core_clk_i);
  endtask

  // Bounded wait for a flag, then one edge more: the ready pin follows the flags a cycle late
  task automatic wait_flag(input logic which);
    for (int i = 0; i < 60 && (which ? oef : ifl) !== 1'b1; i++) @(posedge core_clk_i);
    @(posedge core_clk_i);
  endtask

  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst_n_i, output_clock_i, we, prd, pwr, wdata, cwdata, pnum, oc_cnt, oe_q, sifs, ext_int} = '0;
    void'($urandom(51627));
    repeat (5) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    cmp_word(crdata, CTRL_RST, 16'hFFFF);
    cmp_word({13'h0, sel_oe}, 16'h0001, 16'hFFFF);
    $display("test reset done");
    {sifs, ext_int} <= 2'($urandom);
    ctrl_wr(16'hFFFF);
    cmp_word(crdata, 16'h7BE8 | {sifs, 10'h000, sifs, 3'h0, ext_int}, 16'hFFFF);
    for (int n = 0; n < 8; n++) begin
      port_op(1'b1, 16'($urandom), 3'(n));
      cmp_word({10'h0, sel_oe, sel_o}, 16'(8'h38 + n), 16'hFFFF);
      cmp_bit(ifl | oef, 1'b0);
    end
    $display("test active ports done");
    ctrl_wr(16'h08C0);
    expq.push_back('{16'h0004, 16'h00FF});
    host.read_word(1'b1);
    cmp_word(16'(n_out), 16'h0000, 16'hFFFF);
    $display("test status poll done");
    ctrl_wr(16'h00C0);
    d = 16'($urandom);
    host.write_word(d, 1'b0);
    wait_flag(1'b0);
    cmp_bit(ifl, 1'b1);
    cmp_bit(sel_o[0], 1'b1);
    cmp_word(16'(n_in), 16'h0001, 16'hFFFF);
    expq.push_back('{16'h0002, 16'h00FF});
    host.read_word(1'b1);
    cmp_bit(ifl, 1'b1);
    cmp_word(16'(n_in + n_out), 16'h0001, 16'hFFFF);
    port_op(1'b0, 16'h0000, 3'($urandom));
    cmp_word(rdata, d, 16'hFFFF);
    cmp_bit(ifl, 1'b0);
    host.write_word(~d, 1'b1);
    port_op(1'b0, 16'h0000, 3'($urandom));
    cmp_word(rdata, d, 16'hFFFF);
    cmp_word(16'(n_in), 16'h0001, 16'hFFFF);
    $display("test peripheral write done");
    wd = 16'($urandom);
    port_op(1'b1, wd, 3'($urandom));
    expq.push_back('{wd, 16'hFFFF});
    host.read_word(1'b0);
    cmp_bit(bus_oe_o, 1'b0);
    wait_flag(1'b1);
    cmp_bit(oef, 1'b1);
    cmp_bit(sel_o[0], 1'b1);
    cmp_word(16'(n_out), 16'h0001, 16'hFFFF);
    cmp_bit(expq.size() == 0, 1'b1);
    $display("test peripheral read done");
    finish_test();
  end
endmodule // testbench
